// >>> sbio_port.sv
// Serial bit input/output port of the processor with its memory bus.
// Assumes the core issues commands on ref_clk; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

module sbio_port (
  // Clock, reset and clock enable.
  input  wire logic                            ref_clk,
  input  wire logic                            arst_n,
  input  wire logic                            clkEn,
  // Serial command from the core.
  input  wire logic                            cmdValid,
  input  wire sbio_pkg::sbio_op_e              cmdOp,
  input  wire logic [sbio_pkg::DISP_W-1:0]     cmdDisp,
  input  wire logic [sbio_pkg::COUNT_W-1:0]    cmdCount,
  input  wire logic [sbio_pkg::DATA_W-1:0]     cmdData,
  input  wire logic [sbio_pkg::DATA_W-1:0]     wsPtr,
  output logic                                 cmdReady,
  output logic                                 cmdDone,
  output logic                                 equalFlag,
  output logic      [sbio_pkg::DATA_W-1:0]     cmdInData,
  // Memory request from the core.
  input  wire logic                            memReqValid,
  input  wire logic                            memReqWrite,
  input  wire logic                            memReqByte,
  input  wire logic [sbio_pkg::DATA_W-1:0]     memReqAddr,
  input  wire logic [sbio_pkg::DATA_W-1:0]     memReqData,
  output logic                                 memReqReady,
  output logic                                 memRespValid,
  output logic      [sbio_pkg::DATA_W-1:0]     memRespData,
  // Serial bit pins.
  input  wire logic                            serial_bit_in,
  output logic                                 serial_bit_out,
  output logic                                 serial_bit_strobe,
  // Parallel bus pins.
  output logic      [0:sbio_pkg::ADDR_W-1]     parallel_address_lines,
  output logic      [sbio_pkg::DATA_W-1:0]     parallel_data_lines_out,
  output logic                                 parallel_data_lines_oe,
  input  wire logic [sbio_pkg::DATA_W-1:0]     parallel_data_lines_in,
  output logic                                 memEn_n,
  output logic                                 we_n,
  output logic                                 dbin
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    SP_IDLE, SP_FETCH, SP_FETCH_WAIT, SP_SETUP, SP_STROBE, SP_SAMPLE,
    SP_NEXT, SP_FINISH
  } sbio_sp_e;

  typedef struct packed {
    sbio_sp_e                          st;      // Engine state.
    sbio_pkg::sbio_op_e                op;      // Latched operation.
    logic [sbio_pkg::DATA_W-1:0]       wsBase;  // Even workspace base.
    logic [sbio_pkg::DATA_W-1:0]       base;    // Fetched bit base.
    logic [sbio_pkg::SER_ADDR_W-1:0]   offs;    // Extended displacement.
    logic [sbio_pkg::SER_ADDR_W-1:0]   bitAddr; // Current bit address.
    logic [sbio_pkg::BIT_IDX_W-1:0]    bitIdx;  // Bit within field.
    logic [sbio_pkg::BIT_IDX_W-1:0]    total;   // Field width.
    logic [sbio_pkg::DATA_W-1:0]       shOut;   // Output field.
    logic [sbio_pkg::DATA_W-1:0]       shIn;    // Input field.
    logic [sbio_pkg::CNT_W-1:0]        cnt;     // Wait counter.
    logic                              serOut;  // Output pin.
    logic                              strobe;  // Strobe pin.
    logic                              equal;   // Equal flag.
    logic [sbio_pkg::DATA_W-1:0]       inData;  // Returned field.
    logic                              done;    // Completion pulse.
    logic                              cmdRdy;  // Command ready.
    logic                              memRdy;  // Memory ready.
    logic                              rspV;    // Core access answer, reads and writes.
    logic [sbio_pkg::DATA_W-1:0]       rspD;    // Core read data.
    logic                              inA;     // Input sync stage one.
    logic                              inB;     // Input sync stage two.
    logic [sbio_pkg::DATA_W-1:0]       dA;      // Data sync stage one.
    logic [sbio_pkg::DATA_W-1:0]       dB;      // Data sync stage two.
  } sbio_sp_s;

  localparam sbio_sp_s RST = '{st: SP_IDLE, op: sbio_pkg::SBIO_OP_TEST_BIT,
                               default: '0};

  localparam logic [sbio_pkg::CNT_W-1:0] SETTLE_LAST =
    sbio_pkg::CNT_W'(sbio_pkg::SER_SETTLE_CYC - 1);
  localparam logic [sbio_pkg::CNT_W-1:0] STROBE_LAST =
    sbio_pkg::CNT_W'(sbio_pkg::SER_STROBE_CYC - 1);
  localparam logic [sbio_pkg::CNT_W-1:0] SYNC_LAST =
    sbio_pkg::CNT_W'(sbio_pkg::SYNC_CYC);
  // Byte offset of the base register inside the workspace.
  localparam logic [sbio_pkg::DATA_W-1:0] BASE_REG_OFFS =
    {11'h000, sbio_pkg::BASE_REG_INDEX, 1'b0};

  sbio_sp_s q;  // Registered state.
  sbio_sp_s n;  // Next state.

  // Memory sequencer connections.
  logic                              mReqValid;
  logic                              mReqWrite;
  logic                              mReqByte;
  logic [sbio_pkg::DATA_W-1:0]       mReqAddr;
  logic                              serHold;
  logic                              mReady;
  logic                              mDone;
  logic [sbio_pkg::DATA_W-1:0]       mRdData;
  logic                              coreTake;

  // ****************************************************************
  // Memory request steering
  // ****************************************************************
  // The engine owns the bus from fetch to finish; the core gets it
  // only while ready is shown, so the two never issue together.
  always_comb begin
    coreTake  = memReqValid && q.memRdy;
    mReqValid = coreTake || (q.st == SP_FETCH && mReady);
    mReqWrite = coreTake && memReqWrite;
    mReqByte  = coreTake && memReqByte;
    mReqAddr  = coreTake ? memReqAddr
                         : q.wsBase + BASE_REG_OFFS;
    serHold   = (q.st != SP_IDLE) && (q.st != SP_FETCH) &&
                (q.st != SP_FETCH_WAIT);
  end

  // ****************************************************************
  // Engine next-state logic
  // ****************************************************************
  always_comb begin
    n      = q;
    n.done = 1'b0;
    n.rspV = 1'b0;
    // Pins pass two flip-flops; only the second stage is used.
    n.inA  = serial_bit_in;
    n.inB  = q.inA;
    n.dA   = parallel_data_lines_in;
    n.dB   = q.dA;
    unique case (q.st)
      SP_IDLE: begin
        if (cmdValid && q.cmdRdy && !coreTake) begin
          n.op     = cmdOp;
          n.shOut  = cmdData;
          n.wsBase = {wsPtr[15:1], 1'b0};
          n.offs   = sbio_pkg::sbio_sext(cmdDisp);
          if (cmdOp == sbio_pkg::SBIO_OP_TEST_BIT ||
              cmdOp == sbio_pkg::SBIO_OP_SET_BIT) begin
            n.total = 5'h01;
          end else begin
            // Field code zero selects the full sixteen bits.
            n.offs  = '0;
            n.total = (cmdCount == '0) ? 5'h10 : {1'b0, cmdCount};
          end
          n.st = SP_FETCH;
        end
      end
      SP_FETCH: begin
        if (mReady) begin
          n.st = SP_FETCH_WAIT;
        end
      end
      SP_FETCH_WAIT: begin
        if (mDone) begin
          n.base    = mRdData;
          n.bitIdx  = '0;
          n.bitAddr = sbio_pkg::sbio_bit_addr(mRdData, q.offs);
          n.cnt     = '0;
          n.st      = SP_SETUP;
        end
      end
      SP_SETUP: begin
        // Address and data settle before strobe or sample.
        n.serOut = q.shOut[q.bitIdx[3:0]];
        n.cnt    = q.cnt + 1'b1;
        if (q.cnt == SETTLE_LAST) begin
          n.cnt = '0;
          if (q.op == sbio_pkg::SBIO_OP_SET_BIT ||
              q.op == sbio_pkg::SBIO_OP_MULTI_OUT) begin
            n.strobe = 1'b1;
            n.st     = SP_STROBE;
          end else begin
            n.st = SP_SAMPLE;
          end
        end
      end
      SP_STROBE: begin
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == STROBE_LAST) begin
          n.strobe = 1'b0;
          n.st     = SP_NEXT;
        end
      end
      SP_SAMPLE: begin
        // Wait out the synchroniser so the level is the addressed one.
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == SYNC_LAST) begin
          n.shIn[q.bitIdx[3:0]] = q.inB;
          if (q.op == sbio_pkg::SBIO_OP_TEST_BIT) begin
            n.equal = q.inB;
          end
          n.st = SP_NEXT;
        end
      end
      SP_NEXT: begin
        // Address and output stay put one cycle after the strobe.
        n.bitIdx = q.bitIdx + 1'b1;
        n.cnt    = '0;
        if (n.bitIdx == q.total) begin
          n.st = SP_FINISH;
        end else begin
          n.bitAddr = sbio_pkg::sbio_bit_addr(q.base,
                        q.offs + {7'h00, n.bitIdx});
          n.st      = SP_SETUP;
        end
      end
      SP_FINISH: begin
        n.inData = q.shIn;
        n.shIn   = '0;
        n.done   = 1'b1;
        n.st     = SP_IDLE;
      end
    endcase
    n.cmdRdy = (n.st == SP_IDLE) && mReady && !mReqValid;
    n.memRdy = (n.st == SP_IDLE) && mReady && !mReqValid;
    if (mDone && q.st != SP_FETCH_WAIT) begin
      n.rspV = 1'b1;
      n.rspD = mRdData;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else if (clkEn) begin
      q <= n;
    end
  end

  // ****************************************************************
  // Memory bus sequencer
  // ****************************************************************
  sbio_mem_bus u_mem (
    .clk        (ref_clk),
    .arst_n     (arst_n),
    .clkEn      (clkEn),
    .reqValid   (mReqValid),
    .reqWrite   (mReqWrite),
    .reqByte    (mReqByte),
    .reqAddr    (mReqAddr),
    .reqData    (memReqData),
    .serHold    (serHold),
    .serAddr    (q.bitAddr),
    .ready      (mReady),
    .done       (mDone),
    .rdData     (mRdData),
    .addrLines  (parallel_address_lines),
    .dataOut    (parallel_data_lines_out),
    .dataOe     (parallel_data_lines_oe),
    .dataInSync (q.dB),
    .memEn_n    (memEn_n),
    .we_n       (we_n),
    .dbin       (dbin)
  );

  assign cmdReady          = q.cmdRdy;
  assign cmdDone           = q.done;
  assign equalFlag         = q.equal;
  assign cmdInData         = q.inData;
  assign memReqReady       = q.memRdy;
  assign memRespValid      = q.rspV;
  assign memRespData       = q.rspD;
  assign serial_bit_out    = q.serOut;
  assign serial_bit_strobe = q.strobe;

endmodule

`default_nettype wire

// >>> sbio_pkg.sv
// Shared constants, types and helpers for the serial bit port block.
// Assumes a single 125 MHz clock; no module or process lives here.
`default_nettype none
package sbio_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W     = 16;  // Parallel data word width.
  localparam int ADDR_W     = 15;  // Parallel word address lines.
  localparam int SER_ADDR_W = 12;  // Serial bit address width.
  localparam int DISP_W     = 8;   // Signed displacement width.
  localparam int COUNT_W    = 4;   // Field width code, zero means 16.
  localparam int BIT_IDX_W  = 5;   // Holds bit counts up to 16.
  localparam int CNT_W      = 8;   // Generic wait counter width.

  // ****************************************************************
  // Workspace layout
  // ****************************************************************
  localparam logic [3:0] BASE_REG_INDEX = 4'hc;  // Bit base register.
  localparam int         WS_WORDS       = 16;    // Registers per area.

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  // Least memory access time, rounded up to whole cycles.
  localparam int MEM_ACCESS_NS  = 40;
  localparam int MEM_ACCESS_CYC =
    (MEM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least settle time of the external selector before use.
  localparam int SER_SETTLE_NS  = 48;
  localparam int SER_SETTLE_CYC =
    (SER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least width of the output strobe pulse.
  localparam int SER_STROBE_NS  = 16;
  localparam int SER_STROBE_CYC =
    (SER_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Flip-flops in each pin synchroniser.
  localparam int SYNC_CYC = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0]     DATA_RST  = 16'h0000;
  localparam logic [ADDR_W-1:0]     ADDR_RST  = 15'h0000;
  localparam logic [SER_ADDR_W-1:0] SADDR_RST = 12'h000;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [1:0] {
    SBIO_OP_TEST_BIT,   // Sample one input bit into the equal flag.
    SBIO_OP_SET_BIT,    // Strobe one output bit.
    SBIO_OP_MULTI_OUT,  // Strobe a field of 1 to 16 output bits.
    SBIO_OP_MULTI_IN    // Sample a field of 1 to 16 input bits.
  } sbio_op_e;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Bit address: base register bits 12..1 plus a 12-bit offset.
  function automatic logic [SER_ADDR_W-1:0] sbio_bit_addr(
    input logic [DATA_W-1:0]     base,
    input logic [SER_ADDR_W-1:0] offs
  );
    return base[12:1] + offs;
  endfunction

  // Sign extension of the displacement to the bit address width.
  function automatic logic [SER_ADDR_W-1:0] sbio_sext(
    input logic [DISP_W-1:0] disp
  );
    return {{(SER_ADDR_W - DISP_W){disp[DISP_W-1]}}, disp};
  endfunction

endpackage
`default_nettype wire

// >>> sbio_mem_bus.sv
// Parallel memory bus sequencer: word reads, word writes and byte
// writes by read-modify-write; also parks serial bit addresses.
// Assumes data pins arrive already synchronised by the caller.
`timescale 1ns/1ns
`default_nettype none

module sbio_mem_bus (
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  input  wire logic                           clkEn,
  // Request side.
  input  wire logic                           reqValid,
  input  wire logic                           reqWrite,
  input  wire logic                           reqByte,
  input  wire logic [sbio_pkg::DATA_W-1:0]    reqAddr,
  input  wire logic [sbio_pkg::DATA_W-1:0]    reqData,
  input  wire logic                           serHold,
  input  wire logic [sbio_pkg::SER_ADDR_W-1:0] serAddr,
  output logic                                ready,
  output logic                                done,
  output logic      [sbio_pkg::DATA_W-1:0]    rdData,
  // Pin side.
  output logic      [0:sbio_pkg::ADDR_W-1]    addrLines,
  output logic      [sbio_pkg::DATA_W-1:0]    dataOut,
  output logic                                dataOe,
  input  wire logic [sbio_pkg::DATA_W-1:0]    dataInSync,
  output logic                                memEn_n,
  output logic                                we_n,
  output logic                                dbin
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    MB_IDLE, MB_READ, MB_WR_SETUP, MB_WR_PULSE, MB_WR_HOLD
  } sbio_mb_e;

  typedef struct packed {
    sbio_mb_e                       st;      // Sequencer state.
    logic [0:sbio_pkg::ADDR_W-1]    addr;    // Address pins.
    logic [sbio_pkg::DATA_W-1:0]    wd;      // Write data pins.
    logic                           oe;      // Data pin enable.
    logic                           en_n;    // Memory enable.
    logic                           we_n;    // Write enable.
    logic                           dbin;    // Read direction.
    logic [sbio_pkg::CNT_W-1:0]     cnt;     // Wait counter.
    logic                           isWrite; // Write pending.
    logic                           evenByte;// Even byte is high half.
    logic                           rdy;     // Idle and free.
    logic                           done;    // One-cycle completion.
    logic [sbio_pkg::DATA_W-1:0]    rd;      // Last read word.
  } sbio_mb_s;

  localparam sbio_mb_s RST = '{st: MB_IDLE, en_n: 1'b1, we_n: 1'b1,
                               default: '0};

  // Read waits the access time plus the pin synchroniser.
  localparam logic [sbio_pkg::CNT_W-1:0] READ_LAST =
    sbio_pkg::CNT_W'(sbio_pkg::MEM_ACCESS_CYC + sbio_pkg::SYNC_CYC - 1);
  localparam logic [sbio_pkg::CNT_W-1:0] PULSE_LAST =
    sbio_pkg::CNT_W'(sbio_pkg::MEM_ACCESS_CYC - 1);

  sbio_mb_s q;  // Registered state.
  sbio_mb_s n;  // Next state.

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Byte writes read the word first so the other half is kept.
  always_comb begin
    n      = q;
    n.done = 1'b0;
    unique case (q.st)
      MB_IDLE: begin
        if (reqValid && q.rdy) begin
          n.addr     = reqAddr[15:1];
          n.wd       = reqData;
          n.isWrite  = reqWrite;
          n.evenByte = ~reqAddr[0];
          n.cnt      = '0;
          n.en_n     = 1'b0;
          if (!reqWrite || reqByte) begin
            n.st   = MB_READ;
            n.dbin = 1'b1;
          end else begin
            n.st = MB_WR_SETUP;
            n.oe = 1'b1;
          end
        end else if (serHold) begin
          // Top three lines stay low; they belong to other operations.
          n.addr = {3'b000, serAddr};
        end
      end
      MB_READ: begin
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == READ_LAST) begin
          n.rd   = dataInSync;
          n.dbin = 1'b0;
          n.cnt  = '0;
          if (q.isWrite) begin
            // Merge the new byte, held in the low half of the request.
            n.wd = q.evenByte ? {q.wd[7:0], dataInSync[7:0]}
                              : {dataInSync[15:8], q.wd[7:0]};
            n.oe = 1'b1;
            n.st = MB_WR_SETUP;
          end else begin
            n.en_n = 1'b1;
            n.done = 1'b1;
            n.st   = MB_IDLE;
          end
        end
      end
      MB_WR_SETUP: begin
        // One cycle of address and data setup before the write pulse.
        n.we_n = 1'b0;
        n.cnt  = '0;
        n.st   = MB_WR_PULSE;
      end
      MB_WR_PULSE: begin
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == PULSE_LAST) begin
          n.we_n = 1'b1;
          n.st   = MB_WR_HOLD;
        end
      end
      MB_WR_HOLD: begin
        // Data is held one cycle past the write pulse for hold time.
        n.oe   = 1'b0;
        n.en_n = 1'b1;
        n.done = 1'b1;
        n.st   = MB_IDLE;
      end
    endcase
    n.rdy = (n.st == MB_IDLE) && !(reqValid && q.rdy);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST;
    end else if (clkEn) begin
      q <= n;
    end
  end

  assign ready     = q.rdy;
  assign done      = q.done;
  assign rdData    = q.rd;
  assign addrLines = q.addr;
  assign dataOut   = q.wd;
  assign dataOe    = q.oe;
  assign memEn_n   = q.en_n;
  assign we_n      = q.we_n;
  assign dbin      = q.dbin;

endmodule

`default_nettype wire

// >>> sbio_port_sva.sv
// Checker of the serial bit port: strobe, handshakes, bus enables.
// Assumes clkEn is held high, so pulse widths are fixed.
`timescale 1ns/1ns
`default_nettype none
module sbio_port_sva (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Handshakes.
  input wire logic        cmdValid,
  input wire logic        cmdReady,
  input wire logic        cmdDone,
  input wire logic        memReqValid,
  input wire logic        memReqReady,
  // Pins.
  input wire logic        serial_bit_out,
  input wire logic        serial_bit_strobe,
  input wire logic [0:14] parallel_address_lines,
  input wire logic        parallel_data_lines_oe,
  input wire logic        memEn_n,
  input wire logic        we_n
);
  // ****
  // Properties
  // ****
  // A sixteen bit field with settle time fits well inside this bound.
  localparam int DoneMax = 400;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // A command is taken only when the memory side does not win the tie.
  wire logic take = cmdValid && cmdReady && !(memReqValid && memReqReady);
  chk_strobe_stable: assert property (serial_bit_strobe &&
    $past(serial_bit_strobe) |-> $stable(parallel_address_lines) &&
    $stable(serial_bit_out)) else $error("strobe moved address or data");
  chk_strobe_width: assert property ($rose(serial_bit_strobe)
    |=> serial_bit_strobe ##1 !serial_bit_strobe) else $error("strobe width");
  chk_addr_settled: assert property ($rose(serial_bit_strobe)
    |-> $past(parallel_address_lines, 4) == parallel_address_lines)
    else $error("address not settled before strobe");
  chk_top_lines_zero: assert property (serial_bit_strobe
    |-> parallel_address_lines[0:2] == 3'b000) else $error("A0-A2 not zero");
  chk_done_pulse: assert property (cmdDone |=> !cmdDone)
    else $error("done longer than one cycle");
  chk_take_busy: assert property (take |=> !cmdReady)
    else $error("ready stayed high after take");
  chk_done_bound: assert property (take |-> ##[1:DoneMax] cmdDone)
    else $error("command never finished");
  chk_write_enable: assert property (!we_n
    |-> !memEn_n && parallel_data_lines_oe) else $error("write outside cycle");
  cover property ($rose(serial_bit_strobe));
  cover property (cmdDone);
  cover property (take);
endmodule
bind sbio_port sbio_port_sva sbio_port_sva_inst (.ref_clk, .arst_n,
  .cmdValid, .cmdReady, .cmdDone, .memReqValid, .memReqReady,
  .serial_bit_out, .serial_bit_strobe, .parallel_address_lines,
  .parallel_data_lines_oe, .memEn_n, .we_n);
`default_nettype wire

// >>> sbio_kbd_model.sv
// Keyboard matrix, output bit latches and workspace memory.
// Assumes the port's pins; memory uses the low five word address bits.
`timescale 1ns/1ns
`default_nettype none
module sbio_kbd_model (
  // Pins from the port.
  input  wire logic        clk,
  input  wire logic [0:14] addr,
  input  wire logic [15:0] dOut,
  input  wire logic        memEn_n,
  input  wire logic        we_n,
  input  wire logic        dbin,
  input  wire logic        sOut,
  input  wire logic        sStrobe,
  input  wire logic [63:0] keyDown,
  // Pins back to the port.
  output logic      [15:0] dIn,
  output logic             sIn
);
  logic [15:0] mem [32];  // Word store.
  logic [63:0] latched;   // Output bits caught on the strobe.
  initial foreach (mem[i]) mem[i] = 16'h0000;
  // Released bus shows the inverse so a stale value never passes.
  assign dIn = (!memEn_n && dbin) ? mem[addr[10:14]] : ~mem[addr[10:14]];
  // Column A9-A11 low, row A12-A14 pulled up; a closed key reads zero.
  assign sIn = !keyDown[addr[9:14]];
  always @(posedge clk) begin
    if (!memEn_n && !we_n) mem[addr[10:14]] <= dOut;
    if (sStrobe) latched[addr[9:14]] <= sOut;
  end
endmodule
`default_nettype wire

// >>> serial_bit_io_keyboard_scan_bench.sv
// Self-checking bench of the serial bit port with a keyboard model.
// Assumes clkEn high; one command or memory access at a time.
`timescale 1ns/1ns
`default_nettype none
module serial_bit_io_keyboard_scan_bench;
  typedef struct {
    logic [1:0] op;
    logic [7:0] disp;
    logic [3:0] cnt;
    logic [15:0] data, ws, base;
    logic [5:0] key;
  } sbio_row_s;
  // Op, displacement, count, data, workspace, base, pressed key.
  sbio_row_s rows [7] = '{
    '{2'h0, 8'h7f, 4'h0, 16'h0000, 16'h0000, 16'hffff, 6'h3e},
    '{2'h0, 8'h80, 4'h0, 16'h0000, 16'h0010, 16'h0080, 6'h00},
    '{2'h0, 8'h00, 4'h0, 16'h0000, 16'h0000, 16'h007f, 6'h05},
    '{2'h1, 8'hfd, 4'h0, 16'h0001, 16'h0010, 16'h0010, 6'h00},
    '{2'h2, 8'h00, 4'h0, 16'ha5c3, 16'h0000, 16'h0040, 6'h00},
    '{2'h3, 8'h00, 4'h5, 16'h0000, 16'h0010, 16'h0020, 6'h12},
    '{2'h3, 8'h00, 4'h0, 16'h0000, 16'h0000, 16'h0000, 6'h0f}};
  sbio_row_s row;
  logic ref_clk = 1'b0, arst_n = 1'b0, cmdValid = 1'b0, memReqValid = 1'b0;
  logic memReqWrite = 1'b0, memReqByte = 1'b0;
  sbio_pkg::sbio_op_e cmdOp = sbio_pkg::SBIO_OP_TEST_BIT;
  logic [7:0] cmdDisp = 8'h00;
  logic [3:0] cmdCount = 4'h0;
  logic [15:0] cmdData = 16'h0, wsPtr = 16'h0, memReqAddr = 16'h0;
  logic [15:0] memReqData = 16'h0, cmdInData, memRespData, dOut, dIn;
  logic [63:0] keyDown = 64'h0;
  logic [0:14] addrL;
  logic [11:0] a0;
  logic [5:0] k;
  logic cmdReady, cmdDone, equalFlag, memReqReady, memRespValid;
  logic sIn, sOut, sStrobe, dOe, memEn_n, we_n, dbin;
  int bad_count = 0, n_tests = 0, cycles = 0, n;
  sbio_port sbio_port_inst (.ref_clk, .arst_n, .clkEn(1'b1), .cmdValid,
    .cmdOp, .cmdDisp, .cmdCount, .cmdData, .wsPtr, .cmdReady, .cmdDone,
    .equalFlag, .cmdInData, .memReqValid, .memReqWrite, .memReqByte,
    .memReqAddr, .memReqData, .memReqReady, .memRespValid, .memRespData,
    .serial_bit_in(sIn), .serial_bit_out(sOut), .serial_bit_strobe(sStrobe),
    .parallel_address_lines(addrL), .parallel_data_lines_out(dOut),
    .parallel_data_lines_oe(dOe), .parallel_data_lines_in(dIn), .memEn_n,
    .we_n, .dbin);
  sbio_kbd_model sbio_kbd_model_inst (.clk(ref_clk), .addr(addrL), .dOut,
    .memEn_n, .we_n, .dbin, .sOut, .sStrobe, .keyDown, .dIn, .sIn);
  initial forever #4 ref_clk = ~ref_clk;
  // Counts every comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [15:0] exp, seen);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits, bounded, until a level is seen high just after an edge.
  task automatic waitHigh(ref logic sig);
    for (int t = 0; t < 600 && sig !== 1'b1; t++) @(posedge ref_clk) #1;
    check("wait", 16'h1, sig);
  endtask
  // One memory request, held until the edge that takes it.
  task automatic memOp(input logic w, b, input logic [15:0] a, d);
    memReqWrite = w;
    memReqByte = b;
    memReqAddr = a;
    memReqData = d;
    memReqValid = 1'b1;
    waitHigh(memReqReady);
    @(posedge ref_clk) #1;
    memReqValid = 1'b0;
    waitHigh(memRespValid);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A hang counts as a mismatch and closes the run.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    #18;
    check("reset enable", 16'h1, memEn_n);
    check("reset strobe", 16'h0, sStrobe);
    repeat (4) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    foreach (rows[r]) begin
      row = rows[r];
      keyDown = 64'h1 << row.key;
      wsPtr = row.ws;
      memOp(1'b1, 1'b0, row.ws + 16'h0018, row.base);
      cmdOp = sbio_pkg::sbio_op_e'(row.op);
      cmdDisp = row.disp;
      cmdCount = row.cnt;
      cmdData = row.data;
      cmdValid = 1'b1;
      waitHigh(cmdReady);
      @(posedge ref_clk) #1;
      cmdValid = 1'b0;
      waitHigh(cmdDone);
      a0 = row.base[12:1] + ((row.op < 2) ? {{4{row.disp[7]}}, row.disp} : 0);
      n = (row.op < 2) ? 1 : ((row.cnt == 0) ? 16 : int'(row.cnt));
      for (int i = 0; i < n; i++) begin
        k = 6'(a0 + 12'(i));
        case (row.op)
          2'h0: check("equal flag", !keyDown[k], equalFlag);
          2'h3: check("field bit", !keyDown[k], cmdInData[i]);
          default: check("latched bit", row.data[i],
                         sbio_kbd_model_inst.latched[k]);
        endcase
      end
      check("last address", {4'h0, a0 + 12'(n - 1)}, {1'b0, addrL});
    end
    // Byte write to the odd byte must keep the even byte of the word.
    memOp(1'b1, 1'b0, 16'h0040, 16'h1234);
    memOp(1'b1, 1'b1, 16'h0041, 16'h00ab);
    memOp(1'b0, 1'b0, 16'h0040, 16'h0000);
    check("byte merge", 16'h12ab, memRespData);
    end_sim();
  end
endmodule
`default_nettype wire
